/* hw/tcc_pkg.sv */
// Package with register map, field layout and types of the transfer count/chain controller
package tcc_pkg;

    // ****************************************************************
    // Register offsets (word index on the plain register port)
    // ****************************************************************
    localparam logic [4:0] OFS_MODE_A   = 5'h00;
    localparam logic [4:0] OFS_MODE_B   = 5'h01;
    localparam logic [4:0] OFS_SRC      = 5'h02;
    localparam logic [4:0] OFS_DST      = 5'h03;
    localparam logic [4:0] OFS_CNT_A    = 5'h04;
    localparam logic [4:0] OFS_CNT_B    = 5'h05;
    localparam logic [4:0] OFS_CTRL     = 5'h06;
    localparam logic [4:0] OFS_STATUS   = 5'h07;
    localparam logic [4:0] OFS_ACT_BASE = 5'h08;
    localparam logic [4:0] OFS_SRC_SEL  = 5'h10;

    localparam int unsigned NUM_ACT_REGS = 8;
    localparam int unsigned NUM_SOURCES  = 64;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int unsigned MB_CHAIN_BIT = 7;
    localparam int unsigned MB_IRQS_BIT  = 6;
    localparam int unsigned MA_SIZE_BIT  = 0;
    localparam int unsigned MA_MODE_LSB  = 2;
    localparam int unsigned CTRL_GO_BIT  = 0;
    localparam int unsigned MA_SRC_EN_BIT = 7;
    localparam int unsigned MA_SRC_DN_BIT = 6;
    localparam int unsigned MA_DST_EN_BIT = 5;
    localparam int unsigned MA_DST_DN_BIT = 4;
    localparam int unsigned ACT_REG_W     = 8;

    localparam logic [7:0]  MODE_B_KEEP  = 8'hC0;
    localparam logic [7:0]  ACT_RESET    = 8'h00;
    localparam logic [15:0] CNT_ONE      = 16'h0001;
    localparam logic [7:0]  HALF_ONE     = 8'h01;
    localparam logic [23:0] STEP_BYTE    = 24'h000001;
    localparam logic [23:0] STEP_WORD    = 24'h000002;
    localparam logic [31:0] ZERO_WORD    = 32'h00000000;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_REPEAT = 2'b01,
        MODE_BLOCK  = 2'b10,
        MODE_UNUSED = 2'b11
    } tcc_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_DONE = 2'b10
    } tcc_state_e;

    typedef struct packed {
        logic [4:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tcc_reg_req_s;

endpackage : tcc_pkg

/* hw/tcc_top.sv */
// Transfer counting, chaining and activation-enable control of a data transfer controller
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps

module tcc_top
    import tcc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    // Register port
    input  wire logic [4:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // Activation requests from the interrupt sources
    input  wire logic [63:0] IRQ_REQ_I,
    // System bus transfer
    output logic             XFER_VALID_O,
    output logic      [23:0] XFER_SRC_O,
    output logic      [23:0] XFER_DST_O,
    output logic             XFER_WORD_O,
    input  wire logic        XFER_DONE_I,
    // Results toward the interrupt controller and CPU
    output logic             CPU_IRQ_O,
    output logic             FLAG_CLR_O,
    output logic      [5:0]  SRC_ID_O,
    output logic             CHAIN_NEXT_O
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        tcc_state_e  st;
        logic [7:0]  mode_a;
        logic [7:0]  mode_b;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [63:0] act_en;
        logic [5:0]  src_id;
        logic        last;
        logic [31:0] rdata;
        logic        cpu_irq;
        logic        flag_clr;
        logic        chain_next;
    } tcc_state_s;

    tcc_state_s   s_q;
    tcc_state_s   s_d;
    tcc_reg_req_s req;

    logic [63:0]  pend;
    logic [5:0]   pick;
    logic         any_pend;
    tcc_mode_e    mode;
    logic [23:0]  step;
    logic [7:0]   work_dec;
    logic         work_zero;
    logic         count_end;
    logic         chain;
    logic         irq_each;
    logic         wr_mode_a;
    logic         wr_mode_b;
    logic         wr_src;
    logic         wr_dst;
    logic         wr_cnt_a;
    logic         wr_cnt_b;
    logic         wr_go;
    logic [7:0]   act_wr;
    logic [7:0]   act_rd;
    logic [31:0]  rd_word;
    logic [23:0]  src_next;
    logic [23:0]  dst_next;
    logic [7:0]   work_next;
    logic [15:0]  cnt_a_next;
    logic [15:0]  cnt_b_next;
    logic         end_irq;
    logic         end_clr;
    logic         end_dis;

    assign req.addr  = ADDR_I;
    assign req.wdata = WDATA_I;
    assign req.wr    = WR_I;
    assign req.rd    = RD_I;

    assign pend     = IRQ_REQ_I & s_q.act_en;
    assign any_pend = |pend;
    assign mode     = tcc_mode_e'(s_q.mode_a[MA_MODE_LSB +: 2]);
    assign step     = s_q.mode_a[MA_SIZE_BIT] ? STEP_WORD : STEP_BYTE;
    assign chain    = s_q.mode_b[MB_CHAIN_BIT];
    assign irq_each = s_q.mode_b[MB_IRQS_BIT];

    // Lowest-numbered pending source has priority
    always_comb begin
        pick = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pend[i]) begin
                pick = 6'(i);
            end
        end
    end

    // ****************************************************************
    // Transfer counters
    // ****************************************************************
    // Working half reloads from the reload half in the same step that it runs out
    always_comb begin
        work_dec   = s_q.cnt_a[7:0] - HALF_ONE;
        work_zero  = (work_dec == '0);
        work_next  = work_zero ? s_q.cnt_a[15:8] : work_dec;
        cnt_a_next = s_q.cnt_a;
        cnt_b_next = s_q.cnt_b;
        count_end  = 1'b0;
        case (mode)
            MODE_NORMAL: begin
                cnt_a_next = s_q.cnt_a - CNT_ONE;
                count_end  = (s_q.cnt_a == CNT_ONE);
            end
            MODE_REPEAT: begin
                // Repeat mode never reaches an end of count
                cnt_a_next = {s_q.cnt_a[15:8], work_next};
            end
            MODE_BLOCK: begin
                cnt_a_next = {s_q.cnt_a[15:8], work_next};
                if (work_zero) begin
                    cnt_b_next = s_q.cnt_b - CNT_ONE;
                end
                count_end  = work_zero && (s_q.cnt_b == CNT_ONE);
            end
            default: begin
            end
        endcase
    end

    // ****************************************************************
    // Pointer stepping
    // ****************************************************************
    // Upper bit of each pair enables stepping, lower bit picks the direction
    always_comb begin
        src_next = s_q.src;
        dst_next = s_q.dst;
        if (s_q.mode_a[MA_SRC_EN_BIT]) begin
            if (s_q.mode_a[MA_SRC_DN_BIT]) begin
                src_next = s_q.src - step;
            end else begin
                src_next = s_q.src + step;
            end
        end
        if (s_q.mode_a[MA_DST_EN_BIT]) begin
            if (s_q.mode_a[MA_DST_DN_BIT]) begin
                dst_next = s_q.dst - step;
            end else begin
                dst_next = s_q.dst + step;
            end
        end
    end

    // ****************************************************************
    // End of transfer decisions
    // ****************************************************************
    // A chained step reports nothing, so the source keeps its flag and enable
    always_comb begin
        end_irq = 1'b0;
        end_clr = 1'b0;
        end_dis = 1'b0;
        if (!chain) begin
            if (irq_each || s_q.last) begin
                end_irq = 1'b1;
                end_dis = 1'b1;
            end else begin
                end_clr = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    always_comb begin
        wr_mode_a = 1'b0;
        wr_mode_b = 1'b0;
        wr_src    = 1'b0;
        wr_dst    = 1'b0;
        wr_cnt_a  = 1'b0;
        wr_cnt_b  = 1'b0;
        wr_go     = 1'b0;
        if (req.wr) begin
            case (req.addr)
                OFS_MODE_A: wr_mode_a = 1'b1;
                OFS_MODE_B: wr_mode_b = 1'b1;
                OFS_SRC:    wr_src    = 1'b1;
                OFS_DST:    wr_dst    = 1'b1;
                OFS_CNT_A:  wr_cnt_a  = 1'b1;
                OFS_CNT_B:  wr_cnt_b  = 1'b1;
                OFS_CTRL:   wr_go     = req.wdata[CTRL_GO_BIT];
                default: begin
                end
            endcase
        end
    end

    // One write enable and one read select per activation-enable register
    for (genvar g = 0; g < NUM_ACT_REGS; g++) begin : g_act
        assign act_wr[g] = req.wr && (req.addr == OFS_ACT_BASE + 5'(g));
        assign act_rd[g] = req.rd && (req.addr == OFS_ACT_BASE + 5'(g));
    end

    // ****************************************************************
    // Read data
    // ****************************************************************
    // Unmapped and write-only words read as zero
    always_comb begin
        rd_word = ZERO_WORD;
        if (req.rd) begin
            case (req.addr)
                OFS_MODE_A: rd_word = {24'h000000, s_q.mode_a};
                OFS_MODE_B: rd_word = {24'h000000, s_q.mode_b};
                OFS_SRC:    rd_word = {8'h00, s_q.src};
                OFS_DST:    rd_word = {8'h00, s_q.dst};
                OFS_CNT_A:  rd_word = {16'h0000, s_q.cnt_a};
                OFS_CNT_B:  rd_word = {16'h0000, s_q.cnt_b};
                OFS_STATUS: rd_word = {24'h000000, s_q.last, 1'b0, s_q.src_id};
                default: begin
                end
            endcase
        end
        for (int r = 0; r < NUM_ACT_REGS; r++) begin
            if (act_rd[r]) begin
                rd_word = {24'h000000, s_q.act_en[r*ACT_REG_W +: ACT_REG_W]};
            end
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_d            = s_q;
        s_d.cpu_irq    = 1'b0;
        s_d.flag_clr   = 1'b0;
        s_d.chain_next = 1'b0;
        s_d.rdata      = rd_word;

        if (wr_mode_a) begin
            s_d.mode_a = req.wdata[7:0];
        end
        if (wr_mode_b) begin
            s_d.mode_b = req.wdata[7:0] & MODE_B_KEEP;
        end
        if (wr_src) begin
            s_d.src = req.wdata[23:0];
        end
        if (wr_dst) begin
            s_d.dst = req.wdata[23:0];
        end
        if (wr_cnt_a) begin
            s_d.cnt_a = req.wdata[15:0];
        end
        if (wr_cnt_b) begin
            s_d.cnt_b = req.wdata[15:0];
        end
        // Activation-enable registers A..G and I, one source per bit
        for (int r = 0; r < NUM_ACT_REGS; r++) begin
            if (act_wr[r]) begin
                s_d.act_en[r*ACT_REG_W +: ACT_REG_W] = req.wdata[7:0];
            end
        end

        case (s_q.st)
            ST_IDLE: begin
                if (any_pend) begin
                    s_d.src_id = pick;
                    s_d.st     = ST_XFER;
                end else if (wr_go) begin
                    s_d.st = ST_XFER;
                end
            end
            ST_XFER: begin
                // Counters and pointers move only once the bus has finished the transfer
                if (XFER_DONE_I) begin
                    s_d.src   = src_next;
                    s_d.dst   = dst_next;
                    s_d.cnt_a = cnt_a_next;
                    s_d.cnt_b = cnt_b_next;
                    s_d.last  = count_end;
                    s_d.st    = ST_DONE;
                end
            end
            ST_DONE: begin
                s_d.cpu_irq    = end_irq;
                s_d.flag_clr   = end_clr;
                s_d.chain_next = chain;
                if (end_dis) begin
                    s_d.act_en[s_q.src_id] = 1'b0;
                end
                s_d.st = chain ? ST_XFER : ST_IDLE;
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            s_q        <= '0;
            s_q.st     <= ST_IDLE;
            s_q.act_en <= {NUM_ACT_REGS{ACT_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O      = s_q.rdata;
    assign XFER_VALID_O = (s_q.st == ST_XFER);
    assign XFER_SRC_O   = s_q.src;
    assign XFER_DST_O   = s_q.dst;
    assign XFER_WORD_O  = s_q.mode_a[MA_SIZE_BIT];
    assign CPU_IRQ_O    = s_q.cpu_irq;
    assign FLAG_CLR_O   = s_q.flag_clr;
    assign SRC_ID_O     = s_q.src_id;
    assign CHAIN_NEXT_O = s_q.chain_next;

endmodule : tcc_top

/* bench/tcc_bus_model.sv */
// System bus responder that answers each transfer after a programmable latency
`timescale 1ns/1ps
module tcc_bus_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Transfer handshake
    input  wire logic [3:0] lat_i,
    input  wire logic       valid_i,
    output logic            done_o
);
    logic [3:0] cnt_q;
    // Done is a single pulse; the count restarts so a chained transfer waits again
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt_q <= 4'h0;
        end else if (valid_i && !done_o) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= lat_i - 4'h1) begin
                done_o <= 1'b1;
                cnt_q  <= 4'h0;
            end
        end
    end
endmodule : tcc_bus_model

/* bench/tcc_monitor.sv */
// Port checker of the transfer count and chain controller
`timescale 1ns/1ps
module tcc_monitor (
    // Clock, reset and register read
    input wire logic        CLOCK_I, RST_I, RD_I,
    input wire logic [31:0] RDATA_O,
    // Transfer and result signals
    input wire logic        XFER_VALID_O, XFER_DONE_I, CPU_IRQ_O, FLAG_CLR_O, CHAIN_NEXT_O,
    input wire logic [23:0] XFER_SRC_O, XFER_DST_O
);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    a_valid_ends_done: assert property (XFER_VALID_O && XFER_DONE_I |=> !XFER_VALID_O)
        else $error("transfer valid held after done");
    a_irq_after_done: assert property (CPU_IRQ_O |-> $past(XFER_DONE_I, 2))
        else $error("cpu interrupt not two cycles after done");
    a_clr_after_done: assert property (FLAG_CLR_O |-> $past(XFER_DONE_I, 2))
        else $error("flag clear not two cycles after done");
    a_chain_after_done: assert property (CHAIN_NEXT_O |-> $past(XFER_DONE_I, 2))
        else $error("chain pulse not two cycles after done");
    a_chain_no_clear: assert property (CHAIN_NEXT_O |-> !FLAG_CLR_O)
        else $error("flag cleared on chained transfer");
    a_irq_clr_excl: assert property (FLAG_CLR_O |-> !CPU_IRQ_O)
        else $error("flag clear together with cpu interrupt");
    a_irq_one_cycle: assert property (CPU_IRQ_O |=> !CPU_IRQ_O)
        else $error("cpu interrupt longer than one cycle");
    a_rdata_only_read: assert property (!$past(RD_I) |-> RDATA_O == 32'h00000000)
        else $error("read data outside read cycle");
    a_ptr_hold_xfer: assert property (XFER_VALID_O && $past(XFER_VALID_O) && !$past(XFER_DONE_I)
        |-> $stable(XFER_SRC_O) && $stable(XFER_DST_O))
        else $error("pointers moved during transfer");
    c_irq: cover property (CPU_IRQ_O);
    c_clr: cover property (FLAG_CLR_O);
    c_chain: cover property (CHAIN_NEXT_O);
endmodule : tcc_monitor

/* bench/tb.sv */
// Self-checking testbench of the transfer count and chain controller
`timescale 1ns/1ps
module tb;
    import tcc_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, done;
    logic [4:0]  addr = 5'h00;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic [63:0] irq = 64'h0;
    logic        xv, xw, cirq, fclr, chn, word_seen;
    logic [23:0] xs, xd, src_seen, dst_seen;
    logic [5:0]  sid;
    logic [3:0]  lat = 4'h2;
    int          error_cnt = 0, num_checks = 0, n_irq, n_clr, n_chn;
    always #2 clk = ~clk;
    tcc_top dut_u (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
        .RD_I(rd_s), .RDATA_O(rdata), .IRQ_REQ_I(irq), .XFER_VALID_O(xv), .XFER_SRC_O(xs),
        .XFER_DST_O(xd), .XFER_WORD_O(xw), .XFER_DONE_I(done), .CPU_IRQ_O(cirq),
        .FLAG_CLR_O(fclr), .SRC_ID_O(sid), .CHAIN_NEXT_O(chn));
    tcc_bus_model bus_u (.clk_i(clk), .rst_i(rst), .lat_i(lat), .valid_i(xv), .done_o(done));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task report_and_stop;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk); addr <= a; wdata <= d; wr_s <= 1'b1;
        @(posedge clk); wr_s <= 1'b0;
    endtask : wr
    task rc(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk); addr <= a; rd_s <= 1'b1;
        @(posedge clk); rd_s <= 1'b0;
        #1 chk($sformatf("reg %h", a), rdata, exp);
    endtask : rc
    // Request is dropped once taken so a kept enable bit cannot start a second transfer
    task serve(input int k);
        int i;
        i = 0;
        if (k < NUM_SOURCES) begin
            @(posedge clk);
            irq[k] <= 1'b1;
        end else begin
            wr(OFS_CTRL, 32'h00000001);
        end
        while (xv !== 1'b1 && i < 40) begin @(posedge clk); #1; i++; end
        if (i == 40) begin error_cnt++; report_and_stop(); end
        src_seen = xs; dst_seen = xd; word_seen = xw;
        if (k < NUM_SOURCES) begin
            chk("source id", 32'(sid), 32'(k));
        end
        @(posedge clk); irq <= 64'h0;
        n_irq = 0; n_clr = 0; n_chn = 0;
        repeat (20) begin @(posedge clk); #1; n_irq += cirq; n_clr += fclr; n_chn += chn; end
    endtask : serve
    task do_reset;
        @(posedge clk); rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        do_reset();
        for (int r = 0; r < 8; r++) begin
            rc(5'(OFS_ACT_BASE + r), 32'h00000000);
            wr(5'(OFS_ACT_BASE + r), 32'(8'h01 << r));
            rc(5'(OFS_ACT_BASE + r), 32'(8'h01 << r));
            wr(5'(OFS_ACT_BASE + r), 32'h00000000);
        end
        rc(5'h1F, 32'h00000000);
        wr(OFS_MODE_B, 32'h000000FF);
        rc(OFS_MODE_B, 32'h000000C0);
        // Normal mode, count of two, interrupt only at the end
        wr(OFS_MODE_A, 32'h00000000); wr(OFS_MODE_B, 32'h00000000);
        wr(OFS_SRC, 32'h00123456); wr(OFS_DST, 32'h00ABCDEF);
        wr(OFS_CNT_A, 32'h00000002); wr(5'h09, 32'h00000002);
        serve(9);
        chk("src", 32'(src_seen), 32'h00123456);
        chk("dst", 32'(dst_seen), 32'h00ABCDEF);
        chk("clr", 32'(n_clr), 32'h1);
        chk("irq", 32'(n_irq), 32'h0);
        rc(OFS_CNT_A, 32'h00000001);
        rc(5'h09, 32'h00000002);
        serve(9);
        chk("irq end", 32'(n_irq), 32'h1);
        rc(OFS_CNT_A, 32'h00000000);
        rc(5'h09, 32'h00000000);
        // Repeat mode, word size, source increments, interrupt every transfer, slow bus
        lat <= 4'h6;
        wr(OFS_MODE_A, 32'h00000085); wr(OFS_MODE_B, 32'h00000040);
        wr(OFS_SRC, 32'h00000100); wr(OFS_CNT_A, 32'h00000201); wr(5'h0F, 32'h00000080);
        serve(63);
        chk("word", 32'(word_seen), 32'h1);
        chk("irq each", 32'(n_irq), 32'h1);
        chk("no clr", 32'(n_clr), 32'h0);
        rc(5'h0F, 32'h00000000);
        rc(OFS_CNT_A, 32'h00000202);
        rc(OFS_SRC, 32'h00000102);
        // Block mode, block size one, two blocks
        lat <= 4'h2;
        wr(OFS_MODE_A, 32'h00000008); wr(OFS_MODE_B, 32'h00000000);
        wr(OFS_CNT_A, 32'h00000101); wr(OFS_CNT_B, 32'h00000002); wr(5'h08, 32'h00000001);
        serve(0);
        rc(OFS_CNT_B, 32'h00000001);
        rc(OFS_CNT_A, 32'h00000101);
        rc(5'h08, 32'h00000001);
        serve(0);
        chk("blk end", 32'(n_irq), 32'h1);
        rc(OFS_CNT_B, 32'h00000000);
        rc(5'h08, 32'h00000000);
        // Software start, byte size, source counts down, destination counts up
        wr(OFS_MODE_A, 32'h000000E0);
        wr(OFS_MODE_B, 32'h00000000);
        wr(OFS_SRC, 32'h00000010);
        wr(OFS_DST, 32'h00000020);
        wr(OFS_CNT_A, 32'h00000001);
        serve(NUM_SOURCES);
        chk("sw src", 32'(src_seen), 32'h00000010);
        chk("sw dst", 32'(dst_seen), 32'h00000020);
        chk("sw irq", 32'(n_irq), 32'h1);
        rc(OFS_SRC, 32'h0000000F);
        rc(OFS_DST, 32'h00000021);
        rc(OFS_STATUS, 32'h00000080);
        // Chained transfer keeps enable and flag, then a reset in mid-run
        wr(OFS_MODE_A, 32'h00000000); wr(OFS_MODE_B, 32'h00000080);
        wr(OFS_CNT_A, 32'h00000001); wr(5'h0A, 32'h00000004);
        serve(18);
        chk("chain", 32'(n_chn != 0), 32'h1);
        chk("chain clr", 32'(n_clr), 32'h0);
        chk("chain irq", 32'(n_irq), 32'h0);
        rc(5'h0A, 32'h00000004);
        do_reset();
        rc(5'h0A, 32'h00000000);
        report_and_stop();
    end
endmodule : tb
bind tcc_top tcc_monitor mon_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .XFER_VALID_O(XFER_VALID_O), .XFER_DONE_I(XFER_DONE_I),
    .CPU_IRQ_O(CPU_IRQ_O), .FLAG_CLR_O(FLAG_CLR_O), .CHAIN_NEXT_O(CHAIN_NEXT_O),
    .XFER_SRC_O(XFER_SRC_O), .XFER_DST_O(XFER_DST_O));
